// [logic/rtc_alarm_watchdog_core.v]
// Purpose: timekeeping, alarm, watchdog and host register port
// Assumes: bus, oscillator and supply pins asynchronous, sampled through two flip-flops; rst_n_in used directly
// Notes: open-drain interrupt given as level plus enable
`timescale 1ns/1ps
`default_nettype none
`include "rtc_core_defs.vh"

module rtc_alarm_watchdog_core #(
	parameter [15:0] FREEZE_CYCLES = `FREEZE_CYCLES,
	parameter [15:0] REC_CYCLES = `REC_CYCLES
) (
	// clock and reset
	input wire clk_in,
	input wire rst_n_in,
	// host bus pins
	input wire cs_n_in,
	input wire sram_ce_n_in,
	input wire we_n_in,
	input wire oe_n_in,
	input wire [3:0] addr_in,
	input wire [7:0] data_in,
	output reg [7:0] data_out,
	output reg data_oe_out,
	// oscillator and supply
	input wire osc_in,
	input wire power_good_in,
	// open-drain interrupt / test pin
	output reg interrupt_test_n_out,
	output reg interrupt_test_oe_out
);

	reg [17:0] sync1_r;
	reg [17:0] sync2_r;
	reg osc_d_r;
	reg [15:0] rec_cnt_r;
	reg bus_ok_r;
	reg pwrup_r;
	reg wr_prev_r;
	reg acc_prev_r;
	reg [3:0] wa_r;
	reg [7:0] wd_r;
	reg [3:0] acc_addr_r;
	reg [2:0] acc_cnt_r;
	reg [14:0] pre_r;
	reg [15:0] rclr_cnt_r;
	reg load_r;
	reg chk_r;
	reg af_r;
	reg wf_r;
	reg [10:0] wd_cnt_r;
	reg [7:0] ext_r [0:15];
	reg [7:0] sec_r, min_r, hour_r, day_r, date_r, mon_r, year_r, cent_r;
	integer i;

	// bcd increment with wrap, carry in bit 8
	function [8:0] bcd_inc;
		input [7:0] v;
		input [7:0] maxv;
		input [7:0] minv;
		begin
			if (v == maxv)
				bcd_inc = {1'b1, minv};
			else if (v[3:0] == 4'h9)
				bcd_inc = {1'b0, v[7:4] + 4'h1, 4'h0};
			else
				bcd_inc = {1'b0, v + 8'h01};
		end
	endfunction

	// last date of a month in bcd
	function [7:0] last_date;
		input [7:0] mon;
		input [7:0] yr;
		reg leap;
		begin
			leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6) :
				(yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
			case (mon)
				8'h02: last_date = leap ? 8'h29 : 8'h28;
				8'h04, 8'h06, 8'h09, 8'h11: last_date = 8'h30;
				default: last_date = 8'h31;
			endcase
		end
	endfunction

	// mask pattern to number of fields compared
	function [2:0] alarm_level;
		input [3:0] m;
		begin
			case (m)
				4'hF: alarm_level = 3'h0;
				4'hE: alarm_level = 3'h1;
				4'hC: alarm_level = 3'h2;
				4'h8: alarm_level = 3'h3;
				4'h0: alarm_level = 3'h4;
				default: alarm_level = 3'h0;
			endcase
		end
	endfunction

	// synchronised pins
	wire cs_n = sync2_r[17];
	wire ce_n = sync2_r[16];
	wire we_n = sync2_r[15];
	wire oe_n = sync2_r[14];
	wire [3:0] addr = sync2_r[13:10];
	wire [7:0] din = sync2_r[9:2];
	wire osc_s = sync2_r[1];
	wire pg_s = sync2_r[0];

	wire wr_act = bus_ok_r & ce_n & ~cs_n & ~we_n;
	wire rd_act = bus_ok_r & ce_n & ~cs_n & we_n & ~oe_n;
	wire acc_act = wr_act | rd_act;
	wire wr_end = wr_prev_r & ~wr_act;
	wire acc_end = acc_prev_r & ~acc_act;
	wire clr_flags = acc_end & (acc_addr_r == `ADR_FLAGS) & (acc_cnt_r >= `RC_CYCLES);
	wire wd_restart = acc_end & (acc_addr_r == `ADR_WDOG);

	wire [7:0] ctrl = ext_r[`ADR_CTRL];
	wire [7:0] irqc = ext_r[`ADR_IRQ_CTL];
	wire [7:0] wdog = ext_r[`ADR_WDOG];
	wire run = ~ext_r[`ADR_SEC][`BIT_OSC];
	wire osc_rise = run & osc_s & ~osc_d_r;
	wire sec_tick = osc_rise & (pre_r == `PRE_SEC_END);
	wire six_tick = osc_rise & (pre_r[10:0] == `PRE_SIXTEENTH_END);
	wire refresh = ~ctrl[`BIT_WRITE] & ~ctrl[`BIT_READ] & ~load_r &
		(rclr_cnt_r == FREEZE_CYCLES);

	wire [8:0] s_n = bcd_inc(sec_r, 8'h59, 8'h00);
	wire [8:0] m_n = bcd_inc(min_r, 8'h59, 8'h00);
	wire [8:0] h_n = bcd_inc(hour_r, 8'h23, 8'h00);
	wire [8:0] dy_n = bcd_inc(day_r, 8'h07, 8'h01);
	wire [8:0] dt_n = bcd_inc(date_r, last_date(mon_r, year_r), 8'h01);
	wire [8:0] mo_n = bcd_inc(mon_r, 8'h12, 8'h01);
	wire [8:0] y_n = bcd_inc(year_r, 8'h99, 8'h00);
	wire [8:0] c_n = bcd_inc(cent_r, 8'h39, 8'h00);

	wire [2:0] lvl = alarm_level({ext_r[`ADR_ALM_DATE][`BIT_AMASK],
		ext_r[`ADR_ALM_HOUR][`BIT_AMASK], ext_r[`ADR_ALM_MIN][`BIT_AMASK],
		ext_r[`ADR_ALM_SEC][`BIT_AMASK]});
	wire match = (lvl < 3'h1 || ext_r[`ADR_ALM_SEC][6:0] == sec_r[6:0]) &&
		(lvl < 3'h2 || ext_r[`ADR_ALM_MIN][6:0] == min_r[6:0]) &&
		(lvl < 3'h3 || ext_r[`ADR_ALM_HOUR][5:0] == hour_r[5:0]) &&
		(lvl < 3'h4 || ext_r[`ADR_ALM_DATE][5:0] == date_r[5:0]);
	wire alarm_hit = chk_r & match;

	// watchdog limit in sixteenth-second units
	reg [10:0] wd_limit;
	always @* begin
		case (wdog[1:0])
			2'b00: wd_limit = {6'h00, wdog[6:2]};
			2'b01: wd_limit = {4'h0, wdog[6:2], 2'b00};
			2'b10: wd_limit = {2'b00, wdog[6:2], 4'h0};
			default: wd_limit = {wdog[6:2], 6'h00};
		endcase
	end
	wire wd_en = (wdog[6:2] != 5'h00);
	wire wd_fire = six_tick & wd_en & ~wd_restart & (wd_cnt_r + 11'h001 == wd_limit);

	wire irq_on = (af_r & irqc[`BIT_AE] & (bus_ok_r | irqc[`BIT_ABE])) |
		(wf_r & ~wdog[`BIT_WDS]);
	wire ft_on = run & ext_r[`ADR_DAY][`BIT_FT] & ~irqc[`BIT_AE] &
		(wdog[`BIT_WDS] | (wdog == 8'h00));
	wire irq_n_nxt = irq_on ? 1'b0 : (ft_on ? pre_r[5] : 1'b1);

	// pin synchronisers, supply recovery and bus tracking
	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			sync1_r <= 18'h00000;
			sync2_r <= 18'h00000;
			osc_d_r <= 1'b0;
			rec_cnt_r <= 16'h0000;
			bus_ok_r <= 1'b0;
			pwrup_r <= 1'b0;
			wr_prev_r <= 1'b0;
			acc_prev_r <= 1'b0;
			wa_r <= 4'h0;
			wd_r <= 8'h00;
			acc_addr_r <= 4'h0;
			acc_cnt_r <= 3'h0;
		end else begin
			sync1_r <= {cs_n_in, sram_ce_n_in, we_n_in, oe_n_in, addr_in, data_in,
				osc_in, power_good_in};
			sync2_r <= sync1_r;
			osc_d_r <= osc_s;
			if (!pg_s)
				rec_cnt_r <= 16'h0000;
			else if (rec_cnt_r != REC_CYCLES)
				rec_cnt_r <= rec_cnt_r + 16'h0001;
			bus_ok_r <= pg_s & (rec_cnt_r == REC_CYCLES);
			pwrup_r <= pg_s & (rec_cnt_r == REC_CYCLES) & ~bus_ok_r;
			wr_prev_r <= wr_act;
			acc_prev_r <= acc_act;
			if (wr_act) begin
				wa_r <= addr;
				wd_r <= din;
			end
			if (acc_act) begin
				acc_addr_r <= addr;
				if (!acc_prev_r || addr != acc_addr_r)
					acc_cnt_r <= 3'h1;
				else if (acc_cnt_r != 3'h7)
					acc_cnt_r <= acc_cnt_r + 3'h1;
			end
		end
	end

	// prescaler, freeze timer, calendar counters
	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			pre_r <= 15'h0000;
			rclr_cnt_r <= 16'h0000;
			load_r <= 1'b0;
			chk_r <= 1'b0;
			sec_r <= 8'h00;
			min_r <= 8'h00;
			hour_r <= 8'h00;
			day_r <= 8'h01;
			date_r <= 8'h01;
			mon_r <= 8'h01;
			year_r <= 8'h00;
			cent_r <= 8'h00;
		end else begin
			load_r <= wr_end & (wa_r == `ADR_CTRL) & ~wd_r[`BIT_WRITE] & ctrl[`BIT_WRITE];
			chk_r <= sec_tick;
			if (ctrl[`BIT_READ])
				rclr_cnt_r <= 16'h0000;
			else if (rclr_cnt_r != FREEZE_CYCLES)
				rclr_cnt_r <= rclr_cnt_r + 16'h0001;
			if (load_r)
				pre_r <= 15'h0000;
			else if (osc_rise)
				pre_r <= pre_r + 15'h0001;
			if (load_r) begin
				sec_r <= {1'b0, ext_r[`ADR_SEC][6:0]};
				min_r <= ext_r[`ADR_MIN];
				hour_r <= ext_r[`ADR_HOUR];
				day_r <= {5'h00, ext_r[`ADR_DAY][2:0]};
				date_r <= ext_r[`ADR_DATE];
				mon_r <= ext_r[`ADR_MONTH];
				year_r <= ext_r[`ADR_YEAR];
				cent_r <= {2'b00, ctrl[5:0]};
			end else if (sec_tick) begin
				sec_r <= s_n[7:0];
				if (s_n[8]) begin
					min_r <= m_n[7:0];
					if (m_n[8]) begin
						hour_r <= h_n[7:0];
						if (h_n[8]) begin
							day_r <= dy_n[7:0];
							date_r <= dt_n[7:0];
							if (dt_n[8]) begin
								mon_r <= mo_n[7:0];
								if (mo_n[8]) begin
									year_r <= y_n[7:0];
									if (y_n[8])
										cent_r <= c_n[7:0];
								end
							end
						end
					end
				end
			end
		end
	end

	// host registers, flags, watchdog, pins
	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			for (i = 0; i < 16; i = i + 1)
				ext_r[i] <= `RST_REG;
			ext_r[`ADR_SEC] <= `RST_SEC;
			ext_r[`ADR_WDOG] <= `RST_WDOG;
			af_r <= 1'b0;
			wf_r <= 1'b0;
			wd_cnt_r <= 11'h000;
			data_out <= 8'h00;
			data_oe_out <= 1'b0;
			interrupt_test_n_out <= 1'b1;
			interrupt_test_oe_out <= 1'b0;
		end else begin
			if (refresh) begin
				ext_r[`ADR_CTRL][5:0] <= cent_r[5:0];
				ext_r[`ADR_SEC][6:0] <= sec_r[6:0];
				ext_r[`ADR_MIN] <= min_r;
				ext_r[`ADR_HOUR] <= hour_r;
				ext_r[`ADR_DAY][2:0] <= day_r[2:0];
				ext_r[`ADR_DATE] <= date_r;
				ext_r[`ADR_MONTH] <= mon_r;
				ext_r[`ADR_YEAR] <= year_r;
			end
			if (pwrup_r) begin
				ext_r[`ADR_IRQ_CTL][`BIT_AE] <= 1'b0;
				ext_r[`ADR_IRQ_CTL][`BIT_ABE] <= 1'b0;
				ext_r[`ADR_DAY][`BIT_FT] <= 1'b0;
				ext_r[`ADR_WDOG] <= `RST_WDOG;
			end else if (wr_end && wa_r != `ADR_FLAGS)
				ext_r[wa_r] <= wd_r;
			af_r <= alarm_hit | (af_r & ~clr_flags);
			wf_r <= wd_fire | (wf_r & ~clr_flags & ~wd_restart);
			if (wd_restart || !wd_en || pwrup_r)
				wd_cnt_r <= 11'h000;
			else if (six_tick)
				wd_cnt_r <= wd_fire ? 11'h000 : wd_cnt_r + 11'h001;
			data_out <= (addr == `ADR_FLAGS) ? {wf_r, af_r, 6'h00} : ext_r[addr];
			data_oe_out <= rd_act;
			interrupt_test_n_out <= irq_n_nxt;
			interrupt_test_oe_out <= ~irq_n_nxt;
		end
	end

endmodule // rtc_alarm_watchdog_core
`default_nettype wire

// [logic/rtc_core_defs.vh]
// Purpose: constants for the clock, alarm and watchdog core
// Assumes: 25 MHz system clock, 32.768 kHz oscillator input
// Notes: offsets are the 4-bit register indices
`ifndef RTC_CORE_DEFS_VH
`define RTC_CORE_DEFS_VH

`define ADR_FLAGS 4'h0
`define ADR_ALM_SEC 4'h2
`define ADR_ALM_MIN 4'h3
`define ADR_ALM_HOUR 4'h4
`define ADR_ALM_DATE 4'h5
`define ADR_IRQ_CTL 4'h6
`define ADR_WDOG 4'h7
`define ADR_CTRL 4'h8
`define ADR_SEC 4'h9
`define ADR_MIN 4'hA
`define ADR_HOUR 4'hB
`define ADR_DAY 4'hC
`define ADR_DATE 4'hD
`define ADR_MONTH 4'hE
`define ADR_YEAR 4'hF

`define BIT_WRITE 7
`define BIT_READ 6
`define BIT_OSC 7
`define BIT_FT 6
`define BIT_AE 7
`define BIT_ABE 5
`define BIT_WDS 7
`define BIT_AMASK 7

`define RST_REG 8'h00
`define RST_SEC 8'h80
`define RST_WDOG 8'h00

`define PRE_SEC_END 15'h7FFF
`define PRE_SIXTEENTH_END 11'h7FF
`define CLK_NS 40
`define READ_CYCLE_NS 100
`define RC_CYCLES 3'h3
`define FREEZE_US 500
`define FREEZE_CYCLES 16'h30D4
`define REC_CYCLES 16'h0100

`endif

// [tb/rtc_core_properties.sv]
// Purpose: port checks for the clock core
// Assumes: bound to rtc_alarm_watchdog_core
// Notes: pins pass two sync flops, answers lag three clocks
`timescale 1ns/1ps
`default_nettype none
module rtc_core_properties #(
	parameter [15:0] FREEZE_CYCLES = 16'h0008,
	parameter [15:0] REC_CYCLES = 16'h0004
) (
	// clock and reset
	input wire clk_in,
	input wire rst_n_in,
	// host bus and supply
	input wire cs_n_in,
	input wire sram_ce_n_in,
	input wire we_n_in,
	input wire oe_n_in,
	input wire power_good_in,
	// outputs
	input wire data_oe_out,
	input wire interrupt_test_n_out,
	input wire interrupt_test_oe_out
);
	wire rd_cond = sram_ce_n_in && !cs_n_in && we_n_in && !oe_n_in;
	reg [15:0] pg_cnt_r;
	reg [15:0] quiet_cnt_r;
	reg [2:0] rd_cnt_r;
	// power-good age and length of a settled read
	always @(posedge clk_in) begin
		if (!rst_n_in || !power_good_in)
			pg_cnt_r <= 16'h0000;
		else if (pg_cnt_r != 16'hFFFF)
			pg_cnt_r <= pg_cnt_r + 16'h0001;
		if (!rst_n_in || !cs_n_in || !power_good_in)
			quiet_cnt_r <= 16'h0000;
		else if (quiet_cnt_r != 16'hFFFF)
			quiet_cnt_r <= quiet_cnt_r + 16'h0001;
		if (!rd_cond || pg_cnt_r < REC_CYCLES + 16'h0010)
			rd_cnt_r <= 3'h0;
		else if (rd_cnt_r != 3'h7)
			rd_cnt_r <= rd_cnt_r + 3'h1;
	end
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	sequence s_we_fall;
		!cs_n_in && $fell(we_n_in);
	endsequence
	sequence s_read_held;
		rd_cnt_r == 3'h7;
	endsequence
	a_read_start: assert property ($rose(data_oe_out) |-> $past(rd_cond, 3))
		else $error("data drivers on without a read");
	a_we_off: assert property (s_we_fall |-> ##[1:4] !data_oe_out)
		else $error("drivers stay on after write strobe");
	a_read_held: assert property (s_read_held |-> data_oe_out)
		else $error("no drivers during a settled read");
	a_pf_float: assert property (!power_good_in [*5] |-> !data_oe_out)
		else $error("drivers on while power is bad");
	a_pf_wait: assert property ($rose(power_good_in) |-> !data_oe_out [*8])
		else $error("drivers on before recovery");
	a_pin_pair: assert property (interrupt_test_oe_out == !interrupt_test_n_out)
		else $error("pin enable and level disagree");
	a_irq_low_min: assert property ($rose(interrupt_test_oe_out) |=>
		(interrupt_test_oe_out || quiet_cnt_r < REC_CYCLES + 16'h0008) [*8])
		else $error("interrupt pulse too short");
	a_reset_idle: assert property ($rose(rst_n_in) |-> !data_oe_out && interrupt_test_n_out)
		else $error("outputs not idle after reset");
endmodule // rtc_core_properties
bind rtc_alarm_watchdog_core rtc_core_properties #(
	.FREEZE_CYCLES(FREEZE_CYCLES), .REC_CYCLES(REC_CYCLES)) u_props (
	.clk_in(clk_in), .rst_n_in(rst_n_in), .cs_n_in(cs_n_in),
	.sram_ce_n_in(sram_ce_n_in), .we_n_in(we_n_in),
	.oe_n_in(oe_n_in), .power_good_in(power_good_in), .data_oe_out(data_oe_out),
	.interrupt_test_n_out(interrupt_test_n_out), .interrupt_test_oe_out(interrupt_test_oe_out));
`default_nettype wire

// [tb/host_bus_model.sv]
// Purpose: host processor on the clock core bus pins
// Assumes: pins change on the falling clock edge
// Notes: released data lines show the inverse of the last byte
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
	// clock
	input wire logic clk_in,
	// bus pins towards the core
	output logic cs_n_out,
	output logic ce_n_out,
	output logic we_n_out,
	output logic oe_n_out,
	output logic [3:0] addr_out,
	output logic [7:0] data_out,
	// answer from the core
	input wire logic [7:0] rd_data_in,
	input wire logic rd_oe_in
);
	initial begin
		cs_n_out = 1'b1;
		ce_n_out = 1'b1;
		we_n_out = 1'b1;
		oe_n_out = 1'b1;
		addr_out = 4'h0;
		data_out = 8'h5A;
	end
	// write, address held, strobe high again for recovery
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(negedge clk_in);
		addr_out = a;
		data_out = d;
		cs_n_out = 1'b0;
		we_n_out = 1'b0;
		repeat (6) @(negedge clk_in);
		we_n_out = 1'b1;
		cs_n_out = 1'b1;
		repeat (4) @(negedge clk_in);
		data_out = ~d;
	endtask
	task rd(input logic [3:0] a, output logic [7:0] d, output logic en);
		@(negedge clk_in);
		addr_out = a;
		cs_n_out = 1'b0;
		oe_n_out = 1'b0;
		repeat (8) @(negedge clk_in);
		en = rd_oe_in;
		d = rd_oe_in ? rd_data_in : ~rd_data_in;
		oe_n_out = 1'b1;
		cs_n_out = 1'b1;
		repeat (4) @(negedge clk_in);
	endtask
endmodule // host_bus_model
`default_nettype wire

// [tb/tb_rtc_alarm_watchdog_core.sv]
// Purpose: self-checking bench for the clock core
// Assumes: host model drives the bus pins
// Notes: oscillator runs fast to shorten watchdog and wave counts
`timescale 1ns/1ps
`default_nettype none
module tb_rtc_alarm_watchdog_core;
	logic clk_in, rst_n_in, osc, pg, cs_n, ce_n, we_n, oe_n, en;
	logic [3:0] addr;
	logic [7:0] wd, rdd, exp6, prev;
	logic [31:0] seed;
	wire [7:0] dout;
	wire doe, irq_n, irq_oe;
	integer n_fail, samples_checked, i, k;
	initial begin
		clk_in = 1'b0;
		forever #20 clk_in = ~clk_in;
	end
	initial begin
		osc = 1'b0;
		forever #163 osc = ~osc;
	end
	host_bus_model host (.clk_in(clk_in), .cs_n_out(cs_n), .ce_n_out(ce_n), .we_n_out(we_n),
		.oe_n_out(oe_n), .addr_out(addr), .data_out(wd), .rd_data_in(dout), .rd_oe_in(doe));
	rtc_alarm_watchdog_core #(.FREEZE_CYCLES(16'h0008), .REC_CYCLES(16'h0004)) DUT (
		.clk_in(clk_in), .rst_n_in(rst_n_in), .cs_n_in(cs_n), .sram_ce_n_in(ce_n),
		.we_n_in(we_n), .oe_n_in(oe_n), .addr_in(addr), .data_in(wd), .data_out(dout),
		.data_oe_out(doe), .osc_in(osc), .power_good_in(pg),
		.interrupt_test_n_out(irq_n), .interrupt_test_oe_out(irq_oe));
	function logic [31:0] lfsr(input logic [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task check8(input string name, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask
	// count changes of the interrupt pin
	task edges(input integer n);
		k = 0;
		prev[0] = irq_oe;
		repeat (n) begin
			@(negedge clk_in);
			if (irq_oe !== prev[0]) k++;
			prev[0] = irq_oe;
		end
	endtask
	task report_and_stop;
		$display("checked %0d failed %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		n_fail = 0;
		samples_checked = 0;
		seed = 32'h8B9FA958;
		pg = 1'b1;
		rst_n_in = 1'b0;
		repeat (6) @(negedge clk_in);
		rst_n_in = 1'b1;
		repeat (20) @(negedge clk_in);
		host.rd(4'h7, rdd, en);
		check8("watchdog", 8'h00, rdd);
		host.rd(4'h9, rdd, en);
		check8("seconds", 8'h80, rdd);
		for (i = 2; i < 7; i++) begin
			seed = lfsr(seed);
			host.wr(i[3:0], seed[7:0]);
			host.rd(i[3:0], rdd, en);
			check8("register", seed[7:0], rdd);
		end
		exp6 = seed[7:0] & 8'h5F;
		host.wr(4'h0, 8'hFF);
		host.rd(4'h0, rdd, en);
		check8("flags", 8'h00, rdd);
		host.wr(4'hC, 8'h40);
		host.wr(4'h7, 8'h03);
		pg = 1'b0;
		repeat (5) @(negedge clk_in);
		host.wr(4'h6, 8'hFF);
		host.rd(4'h6, rdd, en);
		check8("drivers", 8'h00, {7'h00, en});
		pg = 1'b1;
		repeat (20) @(negedge clk_in);
		host.rd(4'h6, rdd, en);
		check8("irq control", exp6, rdd);
		host.rd(4'hC, rdd, en);
		check8("test bit", 8'h01, rdd);
		host.rd(4'h7, rdd, en);
		check8("watchdog cleared", 8'h00, rdd);
		host.wr(4'h8, 8'h80);
		host.wr(4'h9, 8'h00);
		host.wr(4'hC, 8'h00);
		edges(600);
		check8("pin idle", 8'h00, k[7:0]);
		host.wr(4'hC, 8'h41);
		host.wr(4'h8, 8'h00);
		repeat (20) @(negedge clk_in);
		host.rd(4'h9, rdd, en);
		check8("seconds", 8'h00, rdd);
		host.rd(4'hC, rdd, en);
		check8("day", 8'h41, rdd);
		edges(1200);
		check8("test wave", 8'h01, {7'h00, k >= 4 && k <= 5});
		host.wr(4'h7, 8'h04);
		for (i = 0; i < 40000 && irq_oe !== 1'b1; i++) @(negedge clk_in);
		check8("watchdog pin", 8'h01, {7'h00, irq_oe});
		if (i < 40000) begin
			check8("watchdog level", 8'h00, {7'h00, irq_n});
			edges(300);
			check8("pin held", 8'h00, k[7:0]);
			host.rd(4'h0, rdd, en);
			check8("flags", 8'h80, rdd);
			repeat (10) @(negedge clk_in);
			check8("pin cleared", 8'h00, {7'h00, irq_oe});
			check8("pin level", 8'h01, {7'h00, irq_n});
		end
		report_and_stop;
	end
endmodule // tb_rtc_alarm_watchdog_core
`default_nettype wire
